// ---- verilog/secc_clock_engine.sv ----
`timescale 1ns/100ps
module secc_clock_engine
  import secc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // command byte stream
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  // static setup from the rest of the engine
  input wire logic ctrl_enable,
  input wire logic [secc_pkg::DIV_W-1:0] half_period_div,
  input wire logic clk_idle_level,
  // target side pins
  input wire logic wait_input_line,
  input wire logic returned_test_clock,
  output logic serial_clk,
  // status
  output logic three_phase_mode,
  output logic adaptive_mode,
  output logic data_hold_stage,
  output logic busy
);
  import secc_pkg::*;

  // all state of the block, registered as one word
  typedef struct packed {
    secc_state_e state;
    secc_stop_e stop;
    logic counted;
    logic three_phase;
    logic adaptive;
    logic active;
    logic [1:0] phase;
    logic [DIV_W-1:0] half_cnt;
    logic [PULSE_W-1:0] pulses;
    logic [7:0] len_lo;
    logic [1:0] wait_sync;
    logic [1:0] ret_sync;
  } secc_regs_s;

  // present and next copy of the state word
  secc_regs_s r_q;
  secc_regs_s r_d;

  // terms shared by the next-state logic
  logic line_s;
  logic ret_s;
  logic half_done;
  logic pulse_end;
  logic stop_hit;
  logic take;

  //////////////////////////////////////////////////////////////////////////
  // derived terms
  always_comb begin
    // only the second synchroniser stage is read, never the raw pins
    line_s = r_q.wait_sync[1];
    ret_s = r_q.ret_sync[1];
    take = cmd_valid && cmd_ready;
    // in adaptive mode the returned clock must echo the current level before any new edge
    half_done = (r_q.half_cnt == half_period_div) &&
                (!r_q.adaptive || (ret_s == serial_clk));
    pulse_end = half_done && (r_q.three_phase ? (r_q.phase == PH_HOLD)
                                              : (r_q.phase == PH_ACTIVE));
    // early stop is judged at pulse boundaries, never mid-pulse
    stop_hit = ((r_q.stop == SECC_STOP_HIGH) && line_s) ||
               ((r_q.stop == SECC_STOP_LOW) && !line_s);
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs; opcodes are refused while clocking, keeping order
  assign cmd_ready = ctrl_enable && (r_q.state != SECC_RUN);
  assign busy = (r_q.state == SECC_RUN);
  // limitation: an idle level changed mid-command shows on the pin at once
  assign serial_clk = r_q.active ? ~clk_idle_level : clk_idle_level;
  assign three_phase_mode = r_q.three_phase;
  assign adaptive_mode = r_q.adaptive;
  assign data_hold_stage = r_q.phase == PH_HOLD;

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_d = r_q;
    // pin synchronisers; stage 0 feeds stage 1 only
    r_d.wait_sync = {r_q.wait_sync[0], wait_input_line};
    r_d.ret_sync = {r_q.ret_sync[0], returned_test_clock};
    case (r_q.state)
      SECC_IDLE: begin
        // mode opcodes end here; clock opcodes go on to length bytes or run, unless the line is already at the awaited level
        if (take) begin
          r_d.counted = 1'b0;
          r_d.stop = SECC_STOP_NONE;
          r_d.half_cnt = RST_HALF_CNT;
          r_d.phase = PH_SETUP;
          case (cmd_data)
            OP_THREE_PHASE_ON: r_d.three_phase = 1'b1;
            OP_THREE_PHASE_OFF: r_d.three_phase = 1'b0;
            OP_ADAPTIVE_ON: r_d.adaptive = 1'b1;
            OP_ADAPTIVE_OFF: r_d.adaptive = 1'b0;
            OP_CLK_BITS: r_d.state = SECC_LEN_BIT;
            OP_CLK_BYTES: r_d.state = SECC_LEN_LO;
            OP_BYTES_OR_HIGH: begin
              r_d.stop = SECC_STOP_HIGH;
              r_d.state = SECC_LEN_LO;
            end
            OP_BYTES_OR_LOW: begin
              r_d.stop = SECC_STOP_LOW;
              r_d.state = SECC_LEN_LO;
            end
            // already at the awaited level: nothing to clock
            OP_CLK_UNTIL_HIGH: begin
              r_d.stop = SECC_STOP_HIGH;
              r_d.state = line_s ? SECC_IDLE : SECC_RUN;
            end
            OP_CLK_UNTIL_LOW: begin
              r_d.stop = SECC_STOP_LOW;
              r_d.state = line_s ? SECC_RUN : SECC_IDLE;
            end
            default: r_d.state = SECC_IDLE; // unknown opcodes are dropped
          endcase
        end
      end
      SECC_LEN_BIT: begin
        // only the low three bits count; the rest of the byte is ignored
        if (take) begin
          r_d.counted = 1'b1;
          r_d.pulses = {16'h0000, cmd_data[BIT_LEN_W-1:0]};
          r_d.state = SECC_RUN;
        end
      end
      SECC_LEN_LO: begin
        // low byte first, parked until the high byte arrives
        if (take) begin
          r_d.len_lo = cmd_data;
          r_d.state = SECC_LEN_HI;
        end
      end
      SECC_LEN_HI: begin
        if (take) begin
          r_d.counted = 1'b1;
          // eight pulses per count step, held as total minus one
          r_d.pulses = {cmd_data, r_q.len_lo, 3'h7};
          r_d.state = SECC_RUN;
        end
      end
      SECC_RUN: begin
        // counted commands hold total minus one, so zero marks the last pulse
        if (half_done) begin
          r_d.half_cnt = RST_HALF_CNT;
          if (pulse_end) begin
            r_d.active = 1'b0;
            r_d.phase = PH_SETUP;
            // continuous commands carry no count, so only the line or disabling the controller ends them
            if (stop_hit || (r_q.counted && (r_q.pulses == RST_PULSES))) begin
              r_d.state = SECC_IDLE;
            end else if (r_q.counted) begin
              r_d.pulses = r_q.pulses - 19'h00001;
            end
          end else if (r_q.phase == PH_SETUP) begin
            r_d.active = 1'b1;
            r_d.phase = PH_ACTIVE;
          end else begin
            // three stages only: a hold half with the clock back at idle
            r_d.active = 1'b0;
            r_d.phase = PH_HOLD;
          end
        end else if (r_q.half_cnt != half_period_div) begin
          // counter parks at the divisor while adaptive mode waits for the echo
          r_d.half_cnt = r_q.half_cnt + 16'h0001;
        end
      end
      default: r_d.state = SECC_IDLE;
    endcase
    // besides the line reaching the awaited level, disabling the controller is the only way out of a wait
    if (!ctrl_enable) begin
      // modes survive the abort; only reset or the off opcodes clear them
      r_d.state = SECC_IDLE;
      r_d.active = 1'b0;
      r_d.phase = PH_SETUP;
      r_d.half_cnt = RST_HALF_CNT;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= '{
        state: SECC_IDLE,
        stop: SECC_STOP_NONE,
        counted: 1'b0,
        three_phase: RST_THREE_PHASE,
        adaptive: RST_ADAPTIVE,
        active: 1'b0,
        phase: PH_SETUP,
        half_cnt: RST_HALF_CNT,
        pulses: RST_PULSES,
        len_lo: 8'h00,
        wait_sync: 2'h0,
        ret_sync: 2'h0
      };
    end else begin
      r_q <= r_d;
    end
  end
endmodule : secc_clock_engine

// ---- verilog/secc_pkg.sv ----
package secc_pkg;
  // opcodes handled by this block
  localparam logic [7:0] OP_THREE_PHASE_ON = 8'h8C;
  localparam logic [7:0] OP_THREE_PHASE_OFF = 8'h8D;
  localparam logic [7:0] OP_CLK_BITS = 8'h8E;
  localparam logic [7:0] OP_CLK_BYTES = 8'h8F;
  localparam logic [7:0] OP_CLK_UNTIL_HIGH = 8'h94;
  localparam logic [7:0] OP_CLK_UNTIL_LOW = 8'h95;
  localparam logic [7:0] OP_ADAPTIVE_ON = 8'h96;
  localparam logic [7:0] OP_ADAPTIVE_OFF = 8'h97;
  localparam logic [7:0] OP_BYTES_OR_HIGH = 8'h9C;
  localparam logic [7:0] OP_BYTES_OR_LOW = 8'h9D;

  // widths of counters and length fields
  localparam int DIV_W = 16;
  localparam int PULSE_W = 19;
  localparam int BIT_LEN_W = 3;

  // values after reset
  localparam logic RST_THREE_PHASE = 1'b0;
  localparam logic RST_ADAPTIVE = 1'b0;
  localparam logic [PULSE_W-1:0] RST_PULSES = 19'h00000;
  localparam logic [DIV_W-1:0] RST_HALF_CNT = 16'h0000;

  // half-period stages of one pulse
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_ACTIVE = 2'h1;
  localparam logic [1:0] PH_HOLD = 2'h2;

  typedef enum logic [2:0] {
    SECC_IDLE,
    SECC_LEN_BIT,
    SECC_LEN_LO,
    SECC_LEN_HI,
    SECC_RUN
  } secc_state_e;

  // how a running clock command ends
  typedef enum logic [1:0] {
    SECC_STOP_NONE,
    SECC_STOP_HIGH,
    SECC_STOP_LOW
  } secc_stop_e;
endpackage : secc_pkg

// ---- test/secc_clock_engine_props.sv ----
`timescale 1ns/100ps
module secc_clock_engine_props
  import secc_pkg::*;
(
  // clock, reset and command stream
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic ctrl_enable,
  // clock pin and status
  input wire logic clk_idle_level,
  input wire logic serial_clk,
  input wire logic three_phase_mode,
  input wire logic adaptive_mode,
  input wire logic data_hold_stage,
  input wire logic busy
);
  wire tk = cmd_valid && cmd_ready;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // mode flags judged by their cause, so a length byte equal to an opcode is harmless
  a_phase_cause: assert property (three_phase_mode != $past(three_phase_mode) |->
    $past(tk) && $past(cmd_data) == (three_phase_mode ? OP_THREE_PHASE_ON : OP_THREE_PHASE_OFF))
    else $error("phase mode change");
  a_adapt_cause: assert property (adaptive_mode != $past(adaptive_mode) |->
    $past(tk) && $past(cmd_data) == (adaptive_mode ? OP_ADAPTIVE_ON : OP_ADAPTIVE_OFF))
    else $error("adaptive mode change");
  a_idle_level: assert property (!busy |-> serial_clk == clk_idle_level)
    else $error("clock off idle");
  a_ready_gate: assert property (busy || !ctrl_enable |-> !cmd_ready)
    else $error("byte taken while busy");
  a_abort_now: assert property (!ctrl_enable |=> !busy)
    else $error("no abort");
  a_setup_first: assert property ($rose(busy) |-> serial_clk == clk_idle_level)
    else $error("no setup half");
  a_busy_cause: assert property ($rose(busy) |-> $past(tk))
    else $error("busy without a byte");
  a_hold_idle: assert property (data_hold_stage |->
    three_phase_mode && serial_clk == clk_idle_level) else $error("bad hold half");
endmodule : secc_clock_engine_props
////////////////////////////////////////////////////////////////////////////////
bind secc_clock_engine secc_clock_engine_props secc_clock_engine_props_inst (
  .core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
  .cmd_ready(cmd_ready), .ctrl_enable(ctrl_enable), .clk_idle_level(clk_idle_level),
  .serial_clk(serial_clk), .three_phase_mode(three_phase_mode),
  .adaptive_mode(adaptive_mode), .data_hold_stage(data_hold_stage), .busy(busy));

// ---- test/secc_target_model.sv ----
`timescale 1ns/100ps
module secc_target_model (
  // clock seen by the target
  input wire logic core_clk,
  input wire logic serial_clk,
  input wire logic [3:0] lag,
  // echo back to the engine
  output logic returned_test_clock
);
  logic [15:0] dl_q = 16'h0000;
  // echo after lag plus one core cycles; a slow target makes the engine wait
  always @(posedge core_clk) dl_q <= {dl_q[14:0], serial_clk};
  assign returned_test_clock = dl_q[lag];
endmodule : secc_target_model

// ---- test/test_serial_engine_clock_commands.sv ----
`timescale 1ns/100ps
module test_serial_engine_clock_commands;
  import secc_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, ctrl_enable = 1'b1;
  logic idle = 1'b0, wait_in = 1'b0, ret_clk, sclk, ready, tpm, adm, hold, busy;
  logic [7:0] cmd_data = 8'h00;
  logic [3:0] lag = 4'h0;
  int errors = 0, check_count = 0, pulses = 0, act = 0, hc = 0, cyc = 0;
  // divisor 3: four core cycles a half, the 400 ns serial clock
  secc_clock_engine secc_clock_engine_inst (.core_clk(core_clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(ready), .ctrl_enable(ctrl_enable),
    .half_period_div(16'h0003), .clk_idle_level(idle), .wait_input_line(wait_in),
    .returned_test_clock(ret_clk), .serial_clk(sclk), .three_phase_mode(tpm),
    .adaptive_mode(adm), .data_hold_stage(hold), .busy(busy));
  secc_target_model secc_target_model_inst (.core_clk(core_clk), .serial_clk(sclk),
    .lag(lag), .returned_test_clock(ret_clk));
  initial forever #25 core_clk = ~core_clk;
  // act and hc taken at the falling edge, clear of the launching edge; pulses counted on each move of sclk off idle; hang guard
  always @(sclk) if (sclk !== idle) pulses++;
  always @(negedge core_clk) begin
    cyc++;
    act += int'(sclk !== idle);
    hc += int'(hold === 1'b1);
    if (cyc == 10000) begin
      errors++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  // valid held from a falling edge until a rising edge sees ready
  task send(input logic [7:0] b);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_data = b;
    while (ready !== 1'b1) @(negedge core_clk);
  endtask : send
  // n bytes, low byte first; for d above zero the wait line flips d cycles after the last
  task cmd(input int n, input logic [23:0] b, input int d);
    pulses = 0;
    act = 0;
    hc = 0;
    for (int i = 0; i < n; i++) send(b[8*i +: 8]);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    repeat (d) @(negedge core_clk);
    if (d > 0) wait_in = ~wait_in;
    repeat (3) @(negedge core_clk);
    while (busy === 1'b1) @(negedge core_clk);
  endtask : cmd
  task t_bits();
    for (int l = 0; l < 8; l += 7) begin
      idle = l[0];
      cmd(2, {8'h00, 8'(l), OP_CLK_BITS}, 0);
      chk(pulses, l + 1);
      chk(act, 4 * (l + 1));
      chk(sclk, idle);
    end
  endtask : t_bits
  task t_bytes();
    for (int l = 0; l < 2; l++) begin
      cmd(3, {8'h00, 8'(l), OP_CLK_BYTES}, 0);
      chk(pulses, 8 * (l + 1));
    end
  endtask : t_bytes
  task t_three();
    for (int m = 1; m >= 0; m--) begin
      cmd(1, m ? OP_THREE_PHASE_ON : OP_THREE_PHASE_OFF, 0);
      chk(tpm, m);
      cmd(2, {8'h00, 8'h03, OP_CLK_BITS}, 0);
      chk(hc, 16 * m);
      chk(act, 16);
    end
  endtask : t_three
  task t_adapt();
    lag = 4'hC;
    for (int m = 1; m >= 0; m--) begin
      cmd(1, m ? OP_ADAPTIVE_ON : OP_ADAPTIVE_OFF, 0);
      chk(adm, m);
      cmd(2, {8'h00, 8'h07, OP_CLK_BITS}, 0);
      chk(pulses, 8);
      chk(act >= 8 * 12, m);
    end
  endtask : t_adapt
  task t_wait();
    logic [7:0] ops [4];
    int p;
    ops = '{OP_CLK_UNTIL_HIGH, OP_CLK_UNTIL_LOW, OP_BYTES_OR_HIGH, OP_BYTES_OR_LOW};
    for (int k = 0; k < 4; k++) begin
      wait_in = k[0];
      cmd(k < 2 ? 1 : 3, {8'h00, 8'h03, ops[k]}, 100);
      p = pulses;
      repeat (20) @(negedge core_clk);
      chk(pulses, p);
      chk(p > 8 && p < 32, 1'b1);
    end
    // line already low and settled: the wait ends with no pulse at all
    cmd(1, OP_CLK_UNTIL_LOW, 0);
    chk(pulses, 0);
  endtask : t_wait
  task t_off();
    wait_in = 1'b0;
    send(OP_CLK_UNTIL_HIGH);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    repeat (300) @(negedge core_clk);
    chk(busy, 1'b1);
    ctrl_enable = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(busy, 1'b0);
    chk(sclk, idle);
    ctrl_enable = 1'b1;
  endtask : t_off
  task results();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    chk(tpm, 1'b0);
    t_bits();
    t_bytes();
    t_three();
    t_adapt();
    t_wait();
    t_off();
    results();
  end
endmodule : test_serial_engine_clock_commands
